// ### design/spc_pll_ctrl.sv
// system pll controller: control bits, source switch and derived clocks
//
// Our own choices: the address map and the plain strobed port.
module spc_pll_ctrl import spc_pkg::*; (
    // clock and reset (reset stands for every global reset)
    input wire logic clk,
    input wire logic rst,
    // register port
    input wire logic [ADDR_W-1:0] reg_addr,
    input wire logic [DATA_W-1:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    output logic [DATA_W-1:0] reg_rdata,
    // crystal and pll analog macro pins
    input wire logic crystal_input,
    input wire logic pll_clk_pin,
    input wire logic pll_lock_pin,
    output logic pll_power_down,
    output logic pll_reset_n,
    output logic [FIELD_W-1:0] pll_multiplier,
    // derived clocks
    output logic domain_clock_one,
    output logic domain_clock_two,
    output logic domain_clock_three,
    output logic domain_clock_five,
    output logic auxiliary_reference_clock,
    output logic bypass_domain_clock,
    output logic clock_output_pin
);

    // pin synchronisers, first stage feeds only the second
    logic ref_s1_q;
    logic ref_s2_q;
    logic pll_s1_q;
    logic pll_s2_q;
    logic lock_s1_q;
    logic lock_s2_q;
    logic ref_prev_q; // for crystal rising edges

    // control bits
    logic mode_q; // mode_select_bit
    logic pwrdn_q; // power_down_bit
    logic pll_reset_bit_q; // pll_reset_bit, one releases
    logic outdis_q; // output_disable_bit
    logic ensrc_q; // enable_source_select_bit
    logic clkout_en_q; // routes bypass clock to the pin
    logic [FIELD_W-1:0] mult_q; // multiplier_field
    logic [FIELD_W-1:0] post_divider_q; // post_divider ratio field
    logic [FIELD_W-1:0] bypass_divider_q; // bypass_divider ratio field

    // gated paths and derived levels
    logic outdis_eff_q; // disable in force on the pll path
    logic pll_gated_q; // pll level after disable gate
    logic clkout_eff_q; // pin enable in force
    logic post_lvl; // post-divided pll level
    logic sys_lvl; // selected system level
    logic bp_lvl; // bypass divider level
    spc_src_t cur_src;
    logic [DOM_COUNT-1:0] dom_lvl;
    logic [2:0] bp_wait_q; // crystal edges spent waiting for bypass

    // bus decode
    wire wr_ctrl = reg_wr && reg_addr == ADDR_CTRL;
    wire wr_mult = reg_wr && reg_addr == ADDR_MULT;
    wire wr_post = reg_wr && reg_addr == ADDR_POST_DIVIDER;
    wire wr_bp = reg_wr && reg_addr == ADDR_BYPASS_DIVIDER;
    wire ref_rise = ref_s2_q && !ref_prev_q;

    // mode select only counts while the enable source bit is clear
    wire sel_pll = mode_q && !ensrc_q;

    // read views
    logic [DATA_W-1:0] ctrl_view;
    logic [DATA_W-1:0] stat_view;
    logic [DATA_W-1:0] rd_mux;

    always_comb begin
        ctrl_view = '0;
        ctrl_view[CTRL_MODE_BIT] = mode_q;
        ctrl_view[CTRL_PWRDN_BIT] = pwrdn_q;
        ctrl_view[CTRL_PLL_RESET_BIT_BIT] = pll_reset_bit_q;
        ctrl_view[CTRL_OUTDIS_BIT] = outdis_q;
        ctrl_view[CTRL_ENSRC_BIT] = ensrc_q;
        ctrl_view[CTRL_CLKOUT_BIT] = clkout_en_q;
        stat_view = '0;
        stat_view[STAT_SRC_BIT] = cur_src == SRC_PLL;
        stat_view[STAT_LOCK_BIT] = lock_s2_q;
        stat_view[STAT_PEND_BIT] = sel_pll != (cur_src == SRC_PLL);
    end

    // read selection, unmapped offsets read zero
    assign rd_mux = (reg_addr == ADDR_CTRL) ? ctrl_view :
                    (reg_addr == ADDR_MULT) ? {{(DATA_W-FIELD_W){1'b0}}, mult_q} :
                    (reg_addr == ADDR_POST_DIVIDER) ? {{(DATA_W-FIELD_W){1'b0}}, post_divider_q} :
                    (reg_addr == ADDR_BYPASS_DIVIDER) ? {{(DATA_W-FIELD_W){1'b0}}, bypass_divider_q} :
                    (reg_addr == ADDR_STATUS) ? stat_view : '0;

    // synchronisers for the three pins
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            ref_s1_q <= 1'b0;
            ref_s2_q <= 1'b0;
            pll_s1_q <= 1'b0;
            pll_s2_q <= 1'b0;
            lock_s1_q <= 1'b0;
            lock_s2_q <= 1'b0;
            ref_prev_q <= 1'b0;
        end else begin
            ref_s1_q <= crystal_input;
            ref_s2_q <= ref_s1_q;
            pll_s1_q <= pll_clk_pin;
            pll_s2_q <= pll_s1_q;
            lock_s1_q <= pll_lock_pin;
            lock_s2_q <= lock_s1_q;
            ref_prev_q <= ref_s2_q;
        end
    end

    // control register; reset powers down and selects bypass
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            mode_q <= RST_MODE;
            pwrdn_q <= RST_PWRDN;
            pll_reset_bit_q <= RST_PLL_RESET_BIT;
            outdis_q <= RST_OUTDIS;
            ensrc_q <= RST_ENSRC;
            clkout_en_q <= RST_CLKOUT;
        end else if (wr_ctrl) begin
            mode_q <= reg_wdata[CTRL_MODE_BIT];
            pwrdn_q <= reg_wdata[CTRL_PWRDN_BIT];
            pll_reset_bit_q <= reg_wdata[CTRL_PLL_RESET_BIT_BIT];
            outdis_q <= reg_wdata[CTRL_OUTDIS_BIT];
            ensrc_q <= reg_wdata[CTRL_ENSRC_BIT];
            clkout_en_q <= reg_wdata[CTRL_CLKOUT_BIT];
        end
    end

    // ratio fields
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            mult_q <= MULT_RESET;
            post_divider_q <= POST_DIVIDER_RESET;
            bypass_divider_q <= BYPASS_DIVIDER_RESET;
        end else begin
            if (wr_mult) mult_q <= reg_wdata[FIELD_W-1:0];
            if (wr_post) post_divider_q <= reg_wdata[FIELD_W-1:0];
            if (wr_bp) bypass_divider_q <= reg_wdata[FIELD_W-1:0];
        end
    end

    // read data one cycle after the strobe, zero otherwise
    always_ff @(posedge clk or posedge rst) begin
        if (rst) reg_rdata <= '0;
        else reg_rdata <= reg_rd ? rd_mux : '0;
    end

    // pins to the pll macro; the macro does the multiplying itself
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            pll_power_down <= RST_PWRDN;
            pll_reset_n <= RST_PLL_RESET_BIT;
            pll_multiplier <= MULT_RESET;
        end else begin
            pll_power_down <= pwrdn_q;
            pll_reset_n <= pll_reset_bit_q;
            pll_multiplier <= mult_q;
        end
    end

    // output disable: gate changes only while the pll level is low,
    // so stopping or restarting never clips a high phase
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            outdis_eff_q <= RST_OUTDIS;
            pll_gated_q <= 1'b0;
        end else begin
            if (!pll_s2_q) outdis_eff_q <= outdis_q;
            pll_gated_q <= pll_s2_q && !outdis_eff_q;
        end
    end

    // post-divider on the pll path
    spc_clk_div #(.RST_RATIO(RATIO_ONE)) u_post (
        .clk(clk),
        .rst(rst),
        .src(pll_gated_q),
        .ratio(spc_ratio(post_divider_q)),
        .div_q(post_lvl)
    );

    // bypass or pll; the pll path only reaches the system when selected
    spc_clk_mux u_mux (
        .clk(clk),
        .rst(rst),
        .ref_lvl(ref_s2_q),
        .pll_lvl(post_lvl),
        .sel(sel_pll),
        .out_q(sys_lvl),
        .cur_q(cur_src)
    );

    // fixed domain dividers; ratios are constants, no register reaches them
    genvar gi;
    generate
        for (gi = 0; gi < DOM_COUNT; gi++) begin : g_dom
            spc_clk_div #(.RST_RATIO(DOM_RATIO[gi])) u_dom (
                .clk(clk),
                .rst(rst),
                .src(sys_lvl),
                .ratio(DOM_RATIO[gi]),
                .div_q(dom_lvl[gi])
            );
        end
    endgenerate

    assign domain_clock_one = dom_lvl[0];
    assign domain_clock_two = dom_lvl[1];
    assign domain_clock_three = dom_lvl[2];
    assign domain_clock_five = dom_lvl[3];

    // bypass divider acts on the reference only
    spc_clk_div #(.RST_RATIO(RATIO_ONE)) u_bp (
        .clk(clk),
        .rst(rst),
        .src(ref_s2_q),
        .ratio(spc_ratio(bypass_divider_q)),
        .div_q(bp_lvl)
    );

    // auxiliary reference and clock pin; one flop each, no pll involved
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            auxiliary_reference_clock <= 1'b0;
            bypass_domain_clock <= 1'b0;
            clkout_eff_q <= RST_CLKOUT;
            clock_output_pin <= 1'b0;
        end else begin
            auxiliary_reference_clock <= ref_s2_q;
            bypass_domain_clock <= bp_lvl;
            // pin enable only moves while the bypass level is low
            if (!bp_lvl) clkout_eff_q <= clkout_en_q;
            clock_output_pin <= bp_lvl && clkout_eff_q;
        end
    end

    // crystal edges spent with bypass requested but pll still in force
    always_ff @(posedge clk or posedge rst) begin
        if (rst) bp_wait_q <= '0;
        else if (sel_pll || cur_src == SRC_REF) bp_wait_q <= '0;
        else if (ref_rise && bp_wait_q != 3'h7) bp_wait_q <= bp_wait_q + 3'h1;
    end

    mult_reset_a: assert property (@(posedge clk)
        $fell(rst) |-> pll_multiplier == MULT_RESET && pll_power_down && !cur_src)
        else $error("multiplier or power state wrong after reset");

    mult_write_a: assert property (@(posedge clk) disable iff (rst)
        wr_mult |-> ##2 pll_multiplier == $past(reg_wdata[FIELD_W-1:0], 2))
        else $error("multiplier write not applied");

    post_write_a: assert property (@(posedge clk) disable iff (rst)
        wr_post |=> post_divider_q == $past(reg_wdata[FIELD_W-1:0]))
        else $error("post-divider write lost");

    pwrdn_pin_a: assert property (@(posedge clk) disable iff (rst)
        wr_ctrl |-> ##2 pll_power_down == $past(reg_wdata[CTRL_PWRDN_BIT], 2))
        else $error("power-down pin does not follow the bit");

    reset_pin_a: assert property (@(posedge clk) disable iff (rst)
        wr_ctrl |-> ##2 pll_reset_n == $past(reg_wdata[CTRL_PLL_RESET_BIT_BIT], 2))
        else $error("pll reset pin does not follow the bit");

    bypass_time_a: assert property (@(posedge clk) disable iff (rst)
        bp_wait_q <= BYPASS_SWITCH_XTAL)
        else $error("bypass switch took over four crystal cycles");

    disable_stop_a: assert property (@(posedge clk) disable iff (rst)
        outdis_eff_q |=> !pll_gated_q)
        else $error("pll level passed while output disabled");

    aux_follow_a: assert property (@(posedge clk) disable iff (rst)
        $rose(ref_s2_q) |=> auxiliary_reference_clock)
        else $error("auxiliary clock lost a reference edge");

    bypass_hold_a: assert property (@(posedge clk) disable iff (rst)
        !sel_pll && cur_src == SRC_REF |=> cur_src == SRC_REF)
        else $error("left bypass without a pll request");

endmodule

// ### design/spc_pkg.sv
// shared constants, types and helpers for the system pll clock controller
package spc_pkg;

    // register bus shape
    localparam int ADDR_W = 8;
    localparam int DATA_W = 32;
    // width of multiplier and divider fields
    localparam int FIELD_W = 5;
    // width of a decoded ratio (field plus one, 1..32)
    localparam int RATIO_W = 6;

    // register offsets (byte addresses)
    localparam logic [ADDR_W-1:0] ADDR_CTRL = 8'h00;
    localparam logic [ADDR_W-1:0] ADDR_MULT = 8'h04;
    localparam logic [ADDR_W-1:0] ADDR_POST_DIVIDER = 8'h08;
    localparam logic [ADDR_W-1:0] ADDR_BYPASS_DIVIDER = 8'h0C;
    localparam logic [ADDR_W-1:0] ADDR_STATUS = 8'h10;

    // control register bit positions
    localparam int CTRL_MODE_BIT = 0;
    localparam int CTRL_PWRDN_BIT = 1;
    localparam int CTRL_PLL_RESET_BIT_BIT = 3;
    localparam int CTRL_OUTDIS_BIT = 4;
    localparam int CTRL_ENSRC_BIT = 5;
    localparam int CTRL_CLKOUT_BIT = 6;

    // status register bit positions
    localparam int STAT_SRC_BIT = 0;
    localparam int STAT_LOCK_BIT = 1;
    localparam int STAT_PEND_BIT = 2;

    // reset values of control bits
    localparam logic RST_MODE = 1'b0;
    localparam logic RST_PWRDN = 1'b1;
    localparam logic RST_PLL_RESET_BIT = 1'b0;
    localparam logic RST_OUTDIS = 1'b1;
    localparam logic RST_ENSRC = 1'b1;
    localparam logic RST_CLKOUT = 1'b1;

    // field reset values: multiplier field 16 means 17x, divider 0 means /1
    localparam logic [FIELD_W-1:0] MULT_RESET = 5'h10;
    localparam logic [FIELD_W-1:0] POST_DIVIDER_RESET = 5'h00;
    localparam logic [FIELD_W-1:0] BYPASS_DIVIDER_RESET = 5'h00;

    // ratio of one, used as divider reset ratio
    localparam logic [RATIO_W-1:0] RATIO_ONE = 6'h01;

    // fixed domain ratios: one, two, three, six
    localparam int DOM_COUNT = 4;
    localparam logic [RATIO_W-1:0] DOM_RATIO [0:DOM_COUNT-1] = '{6'h01, 6'h02, 6'h03, 6'h06};

    // longest bypass switch, in crystal cycles
    localparam int BYPASS_SWITCH_XTAL = 4;

    // selected source of the system clock
    typedef enum logic {
        SRC_REF,
        SRC_PLL
    } spc_src_t;

    // field to ratio: stored value plus one
    function automatic logic [RATIO_W-1:0] spc_ratio(input logic [FIELD_W-1:0] f);
        spc_ratio = {1'b0, f} + RATIO_ONE;
    endfunction

endpackage

// ### design/spc_clk_div.sv
// glitch-free clock divider working on sampled clock levels
module spc_clk_div import spc_pkg::*; #(
    parameter logic [RATIO_W-1:0] RST_RATIO = 6'h01
) (
    // clock and reset
    input wire logic clk,
    input wire logic rst,
    // source level and requested ratio
    input wire logic src,
    input wire logic [RATIO_W-1:0] ratio,
    // divided level
    output logic div_q
);

    logic src_prev_q; // source level one cycle ago
    logic [RATIO_W:0] cnt_q; // half-period counter
    logic [RATIO_W:0] cnt_d;
    logic [RATIO_W-1:0] ratio_q; // ratio in force
    logic [RATIO_W-1:0] ratio_d;
    wire toggle = src != src_prev_q; // either edge of the source
    wire [RATIO_W:0] span = {ratio_q, 1'b0}; // half-periods per output period
    wire wrap = cnt_q == span - 7'h01;

    // new ratio is taken only at the period boundary, so no runt pulse
    assign ratio_d = (toggle && wrap) ? ratio : ratio_q;
    assign cnt_d = !toggle ? cnt_q : (wrap ? '0 : cnt_q + 7'h01);

    // counter, ratio and output level
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            src_prev_q <= 1'b0;
            cnt_q <= '0;
            ratio_q <= RST_RATIO;
            div_q <= 1'b0;
        end else begin
            src_prev_q <= src;
            cnt_q <= cnt_d;
            ratio_q <= ratio_d;
            // high for the first half of each period, odd ratios keep 50 %
            div_q <= toggle ? (cnt_d < {1'b0, ratio_d}) : div_q;
        end
    end

    ratio_hold_a: assert property (@(posedge clk) disable iff (rst)
        $changed(ratio_q) |-> $past(wrap) && $past(toggle))
        else $error("divider ratio changed inside a period");

    count_bound_a: assert property (@(posedge clk) disable iff (rst)
        cnt_q < span)
        else $error("divider count past its period");

endmodule

// ### design/spc_clk_mux.sv
// glitch-free two-input clock source switch
module spc_clk_mux import spc_pkg::*; (
    // clock and reset
    input wire logic clk,
    input wire logic rst,
    // reference and pll levels
    input wire logic ref_lvl,
    input wire logic pll_lvl,
    // requested source, 1 selects pll
    input wire logic sel,
    // selected level and source in force
    output logic out_q,
    output spc_src_t cur_q
);

    logic sel_s1_q; // select stage one
    logic sel_s2_q; // select stage two
    spc_src_t want;
    wire both_low = !ref_lvl && !pll_lvl;

    assign want = sel_s2_q ? SRC_PLL : SRC_REF;

    // select stages, then switch only with both inputs low
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            sel_s1_q <= 1'b0;
            sel_s2_q <= 1'b0;
            cur_q <= SRC_REF;
            out_q <= 1'b0;
        end else begin
            sel_s1_q <= sel;
            sel_s2_q <= sel_s1_q;
            // old level must already have stood low a cycle, so the low
            // phase seen downstream is never cut to a single cycle
            if (want != cur_q && both_low && !out_q) begin
                cur_q <= want;
            end
            case (cur_q)
                SRC_REF: out_q <= ref_lvl;
                SRC_PLL: out_q <= pll_lvl;
                default: out_q <= 1'b0;
            endcase
        end
    end

    switch_low_a: assert property (@(posedge clk) disable iff (rst)
        $changed(cur_q) |-> !$past(ref_lvl) && !$past(pll_lvl) && !$past(out_q))
        else $error("source switched while an input was high");

endmodule

// ### tb/spc_pll_ctrl_tb.sv
// self-checking bench for the system pll clock controller
module spc_pll_ctrl_tb import spc_pkg::*;;
    timeunit 1ns;
    timeprecision 1ps;

    // design ports
    logic clk, rst, reg_wr, reg_rd;
    logic [ADDR_W-1:0] reg_addr;
    logic [DATA_W-1:0] reg_wdata, reg_rdata;
    logic crystal_input, pll_clk_pin, pll_lock_pin;
    logic pll_power_down, pll_reset_n;
    logic [FIELD_W-1:0] pll_multiplier;
    logic domain_clock_one, domain_clock_two, domain_clock_three, domain_clock_five;
    logic auxiliary_reference_clock, bypass_domain_clock, clock_output_pin;
    // bench state: counters, register model, edge counts
    integer n_fail = 0;
    integer checked = 0;
    integer seed = 32'h0300;
    int cnt [0:8];
    int mdl [0:3];
    int msk [0:3] = '{32'h0000_007B, 32'h0000_001F, 32'h0000_001F, 32'h0000_001F};
    bit pll_run;
    int run_len;
    logic prev_one;
    logic [31:0] v;
    int i;

    spc_pll_ctrl dut (.clk(clk), .rst(rst), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
        .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
        .crystal_input(crystal_input), .pll_clk_pin(pll_clk_pin),
        .pll_lock_pin(pll_lock_pin), .pll_power_down(pll_power_down),
        .pll_reset_n(pll_reset_n), .pll_multiplier(pll_multiplier),
        .domain_clock_one(domain_clock_one), .domain_clock_two(domain_clock_two),
        .domain_clock_three(domain_clock_three), .domain_clock_five(domain_clock_five),
        .auxiliary_reference_clock(auxiliary_reference_clock),
        .bypass_domain_clock(bypass_domain_clock), .clock_output_pin(clock_output_pin));

    // 125 MHz system clock, 27 MHz crystal, slow pll so 125 MHz sampling keeps up
    always #4 clk = ~clk;
    always #18.519 crystal_input = ~crystal_input;
    always #24 if (pll_run) pll_clk_pin = ~pll_clk_pin;

    // rising edge counters, one slot per clock
    always @(posedge crystal_input) cnt[0]++;
    always @(posedge pll_clk_pin) cnt[1]++;
    always @(posedge domain_clock_one) cnt[2]++;
    always @(posedge domain_clock_two) cnt[3]++;
    always @(posedge domain_clock_three) cnt[4]++;
    always @(posedge domain_clock_five) cnt[5]++;
    always @(posedge auxiliary_reference_clock) cnt[6]++;
    always @(posedge bypass_domain_clock) cnt[7]++;
    always @(posedge clock_output_pin) cnt[8]++;

    // exact compare of design values
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        checked++;
        if (got !== exp) begin
            n_fail++;
            $display("CHECK FAILED at %0t: got %h exp %h", $time, got, exp);
        end
    endtask

    // edge counts may differ by one at the window borders
    task automatic near(input int got, input int exp);
        checked++;
        if (got > exp + 1 || got < exp - 1) begin
            n_fail++;
            $display("CHECK FAILED at %0t: got %h exp %h", $time, got, exp);
        end
    endtask

    // runt watch: a level shorter than two system cycles is a glitch
    always @(posedge clk) begin
        if (rst) begin
            run_len = 8;
        end else if (domain_clock_one !== prev_one) begin
            chk(32'(run_len >= 2), 32'h0000_0001);
            run_len = 1;
        end else begin
            run_len++;
        end
        prev_one = domain_clock_one;
    end

    // one write cycle; model keeps only the implemented bits
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge clk);
        reg_addr <= a;
        reg_wdata <= d;
        reg_wr <= 1'b1;
        @(posedge clk);
        reg_wr <= 1'b0;
        if (a < 8'h10 && a[1:0] == 2'b00) mdl[a >> 2] = d & msk[a >> 2];
    endtask

    // one read cycle; data stands one cycle, then returns to zero
    task automatic rd(input logic [7:0] a, output logic [31:0] d);
        @(posedge clk);
        reg_addr <= a;
        reg_rd <= 1'b1;
        @(posedge clk);
        reg_rd <= 1'b0;
        #1;
        d = reg_rdata;
        @(posedge clk);
        #1;
        chk(reg_rdata, 32'h0000_0000);
    endtask

    task automatic rdc(input logic [7:0] a, input logic [31:0] exp);
        logic [31:0] d;
        rd(a, d);
        chk(d, exp);
    endtask

    // pins follow a write two cycles after the write cycle
    task automatic pins_settle();
        repeat (2) @(posedge clk);
        #1;
    endtask

    // count edges over a window; src 0 crystal, 1 pll through post divider, 2 stopped
    task automatic meas(input int src, input string name);
        int s;
        cnt = '{default: 0};
        repeat (3000) @(posedge clk);
        s = (src == 0) ? cnt[0] : (src == 1) ? cnt[1] / (mdl[2] + 1) : 0;
        near(cnt[2], s);
        near(cnt[3], s / 2);
        near(cnt[4], s / 3);
        near(cnt[5], s / 6);
        near(cnt[6], cnt[0]);
        near(cnt[7], cnt[0] / (mdl[3] + 1));
        near(cnt[8], ((mdl[0] >> 6) & 1) ? cnt[7] : 0);
        $display("test done: %s", name);
    endtask

    task automatic print_verdict();
        $display("comparisons %0d, mismatches %0d", checked, n_fail);
        if (n_fail == 0 && checked > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask

    // hang guard
    initial begin
        #600_000;
        n_fail++;
        $display("CHECK FAILED at %0t: got %h exp %h", $time, 0, 1);
        print_verdict();
    end

    // main sequence
    initial begin
        clk = 1'b0;
        rst = 1'b1;
        reg_addr = '0;
        reg_wdata = '0;
        reg_wr = 1'b0;
        reg_rd = 1'b0;
        crystal_input = 1'b0;
        pll_clk_pin = 1'b0;
        pll_lock_pin = 1'b0;
        pll_run = 1'b0;
        mdl = '{32'h0000_0072, 32'h0000_0010, 0, 0};
        repeat (2) @(posedge clk);
        rst <= 1'b0;
        @(posedge clk);
        #1;
        // power-up state at the pins and in the registers
        chk(32'(pll_power_down), 32'h0000_0001);
        chk(32'(pll_reset_n), 32'h0000_0000);
        chk(32'(pll_multiplier), 32'h0000_0010);
        for (i = 0; i < 4; i++) rdc(8'(i * 4), mdl[i]);
        rdc(ADDR_STATUS, 32'h0000_0000);
        // unmapped places: write ignored, read zero
        wr(8'h20, 32'hFFFF_FFFF);
        rdc(8'h14, 32'h0000_0000);
        // mode bit alone is ignored while the enable source bit is set
        wr(ADDR_CTRL, 32'h0000_0073);
        repeat (20) @(posedge clk);
        rdc(ADDR_STATUS, 32'h0000_0000);
        wr(ADDR_CTRL, 32'h0000_0072);
        for (i = 0; i < 4; i++) rdc(8'(i * 4), mdl[i]);
        $display("test done: reset and map");
        meas(0, "bypass ratios");
        // random multipliers and bypass dividers, upper bits written as noise
        for (i = 0; i < 3; i++) begin
            wr(ADDR_MULT, $random(seed));
            wr(ADDR_BYPASS_DIVIDER, $random(seed));
            pins_settle();
            chk(32'(pll_multiplier), mdl[1]);
            rdc(ADDR_BYPASS_DIVIDER, mdl[3]);
            // old ratio ends its period first, up to 32 crystal cycles
            repeat (200) @(posedge clk);
            meas(0, "random bypass divider");
        end
        // power-down reads one, so the full start-up sequence follows
        rdc(ADDR_CTRL, mdl[0]);
        // full start-up sequence towards pll mode
        wr(ADDR_CTRL, 32'h0000_0052);
        wr(ADDR_CTRL, 32'h0000_0050);
        pins_settle();
        chk(32'(pll_power_down), 32'h0000_0000);
        wr(ADDR_CTRL, 32'h0000_0040);
        wr(ADDR_MULT, 32'h0000_0015);
        wr(ADDR_POST_DIVIDER, 32'h0000_0001);
        wr(ADDR_CTRL, 32'h0000_0048);
        pins_settle();
        chk(32'(pll_multiplier), 32'h0000_0015);
        chk(32'(pll_reset_n), 32'h0000_0001);
        rdc(ADDR_POST_DIVIDER, 32'h0000_0001);
        pll_run = 1'b1;
        pll_lock_pin = 1'b1;
        repeat (20) @(posedge clk);
        rdc(ADDR_STATUS, 32'h0000_0002);
        wr(ADDR_CTRL, 32'h0000_0049);
        v = '0;
        for (i = 0; i < 50 && v[STAT_SRC_BIT] !== 1'b1; i++) rd(ADDR_STATUS, v);
        chk(v, 32'h0000_0003);
        meas(1, "pll mode ratios");
        // output disable stops the pll path; clock-out enable cleared too
        wr(ADDR_CTRL, 32'h0000_0019);
        meas(2, "pll output disabled");
        wr(ADDR_CTRL, 32'h0000_0049);
        // let the pll path toggle again before asking for bypass
        repeat (40) @(posedge clk);
        // back to bypass: bounded by crystal edges
        wr(ADDR_CTRL, 32'h0000_0048);
        cnt[0] = 0;
        v = 32'h0000_0001;
        for (i = 0; i < 50 && v[STAT_SRC_BIT] !== 1'b0; i++) rd(ADDR_STATUS, v);
        // one spare edge covers the read latency of the poll
        chk(32'(cnt[0] <= BYPASS_SWITCH_XTAL + 1), 32'h0000_0001);
        chk(v, 32'h0000_0002);
        meas(0, "return to bypass");
        // reset in mid-run powers the pll down again
        @(posedge clk);
        rst <= 1'b1;
        repeat (2) @(posedge clk);
        #1;
        chk(32'(pll_power_down), 32'h0000_0001);
        chk(32'(pll_reset_n), 32'h0000_0000);
        @(posedge clk);
        rst <= 1'b0;
        mdl = '{32'h0000_0072, 32'h0000_0010, 0, 0};
        for (i = 0; i < 4; i++) rdc(8'(i * 4), mdl[i]);
        chk(32'(pll_multiplier), 32'h0000_0010);
        meas(0, "bypass after reset");
        print_verdict();
    end
endmodule
